// ==== pkg/thermal_cfg_pkg.sv ====
// Constants, field layout and state types of the sensor configuration block.
// Assumes temperatures in 1/16 degree steps and limits in 1/4 degree steps.
package thermal_cfg_pkg;

    localparam int CFG_WIDTH = 16;
    localparam int TEMP_WIDTH = 13;

    localparam int BIT_EVENT_MODE = 0;
    localparam int BIT_POLARITY = 1;
    localparam int BIT_CRIT_ONLY = 2;
    localparam int BIT_OUT_ENABLE = 3;
    localparam int BIT_STATUS = 4;
    localparam int BIT_CLEAR = 5;
    localparam int BIT_ALARM_LOCK = 6;
    localparam int BIT_CRIT_LOCK = 7;
    localparam int BIT_SHUTDOWN = 8;
    localparam int BIT_HYST_LO = 9;
    localparam int BIT_HYST_HI = 10;

    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Limit registers keep a 1/4 degree value in bits 12:2
    localparam int LIMIT_MSB = 12;
    localparam int LIMIT_LSB = 2;

    localparam logic [1:0] HYST_SEL_NONE = 2'h0;
    localparam logic [1:0] HYST_SEL_1P5 = 2'h1;
    localparam logic [1:0] HYST_SEL_3 = 2'h2;
    localparam logic [1:0] HYST_SEL_6 = 2'h3;

    // Hysteresis in 1/16 degree steps
    localparam logic [12:0] HYST_NONE = 13'h0000;
    localparam logic [12:0] HYST_1P5 = 13'h0018;
    localparam logic [12:0] HYST_3 = 13'h0030;
    localparam logic [12:0] HYST_6 = 13'h0060;

    typedef struct packed {
        logic [15:0] rdata;
        logic event_level;
        logic event_oe;
        logic [1:0] hysteresis;
        logic shutdown;
        logic crit_lock;
        logic alarm_lock;
        logic status;
        logic out_enable;
        logic crit_only;
        logic polarity;
        logic event_mode;
        logic event_latched;
        logic cond_prev;
    } cfg_state_type;

    localparam cfg_state_type CFG_STATE_RESET = '{
        rdata: 16'h0000,
        event_level: 1'b1,
        event_oe: 1'b0,
        hysteresis: 2'h0,
        shutdown: 1'b0,
        crit_lock: 1'b0,
        alarm_lock: 1'b0,
        status: 1'b0,
        out_enable: 1'b0,
        crit_only: 1'b0,
        polarity: 1'b0,
        event_mode: 1'b0,
        event_latched: 1'b0,
        cond_prev: 1'b0
    };

    typedef struct packed {
        logic tripped;
    } trip_state_type;

endpackage

// ==== pkg/trip_if.sv ====
// Carries the live temperature and hysteresis to the trip comparators.
// Assumes one source module and any number of comparator sinks.
interface trip_if;
    logic [12:0] temperature;
    logic [12:0] hysteresis;
    logic sample_valid;
    logic run;

    modport source(
        output temperature,
        output hysteresis,
        output sample_valid,
        output run
    );

    modport sink(
        input temperature,
        input hysteresis,
        input sample_valid,
        input run
    );
endinterface

// ==== hw/trip_compare.sv ====
// One temperature limit comparator with hysteresis on the return crossing.
// Assumes temperature and limit are signed, both in 1/16 degree steps.
module trip_compare #(
    parameter bit TRIP_ABOVE = 1'b1,
    parameter bit INCLUSIVE = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    trip_if.sink link,
    input wire logic [12:0] limit,
    output logic tripped
);
    import thermal_cfg_pkg::*;

    thermal_cfg_pkg::trip_state_type state;
    thermal_cfg_pkg::trip_state_type next_state;

    logic signed [13:0] temp_w;
    logic signed [13:0] limit_w;
    logic signed [13:0] hyst_w;
    logic signed [13:0] release_low;
    logic signed [13:0] release_high;

    assign temp_w = {link.temperature[12], link.temperature};
    assign limit_w = {limit[12], limit};
    assign hyst_w = {1'b0, link.hysteresis};
    assign release_low = limit_w - hyst_w;
    assign release_high = limit_w + hyst_w;

    always_comb begin
        next_state = state;
        if (!link.run) begin
            next_state.tripped = 1'b0;
        end else if (link.sample_valid) begin
            if (!state.tripped) begin
                if (TRIP_ABOVE) begin
                    next_state.tripped = INCLUSIVE ? (temp_w >= limit_w) : (temp_w > limit_w);
                end else begin
                    next_state.tripped = temp_w < limit_w;
                end
            end else begin
                // Release only once the temperature is past the hysteresis band
                if (TRIP_ABOVE) begin
                    next_state.tripped = INCLUSIVE ? !(temp_w < release_low)
                                                   : !(temp_w <= release_low);
                end else begin
                    next_state.tripped = !(temp_w >= release_high);
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tripped = state.tripped;
endmodule

// ==== hw/thermal_sensor_config_event_control.sv ====
// Configuration register and event output control of the temperature sensor.
// Assumes the serial slave presents one-cycle register strobes on clk, and
// the converter and limit registers sit on the same clock outside.
module thermal_sensor_config_event_control (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_write,
    input wire logic [thermal_cfg_pkg::CFG_WIDTH-1:0] cfg_wdata,
    output logic [thermal_cfg_pkg::CFG_WIDTH-1:0] cfg_rdata,
    input wire logic [thermal_cfg_pkg::TEMP_WIDTH-1:0] temperature,
    input wire logic sample_valid,
    input wire logic [15:0] upper_limit,
    input wire logic [15:0] lower_limit,
    input wire logic [15:0] critical_limit,
    input wire logic upper_write_req,
    input wire logic lower_write_req,
    input wire logic critical_write_req,
    output logic upper_write_grant,
    output logic lower_write_grant,
    output logic critical_write_grant,
    output logic temperature_sensing,
    output logic above_critical,
    output logic above_alarm,
    output logic below_alarm,
    output logic event_status,
    output logic event_level,
    output logic event_pin_o,
    output logic event_pin_oe
);
    import thermal_cfg_pkg::*;

    cfg_state_type state;
    cfg_state_type next_state;

    trip_if link();

    logic [12:0] upper_scaled;
    logic [12:0] lower_scaled;
    logic [12:0] critical_scaled;
    logic [12:0] hyst_amount;
    logic crit_trip;
    logic upper_trip;
    logic lower_trip;
    logic locked;
    logic clear_request;
    logic event_cond;
    logic cond_rise;
    logic active;
    logic asserted;

    // Limits carry quarter degrees in bits 12:2; clear bits 1:0 to fit the 1/16 degree grid of the sensor
    assign upper_scaled = {upper_limit[LIMIT_MSB:LIMIT_LSB], 2'h0};
    assign lower_scaled = {lower_limit[LIMIT_MSB:LIMIT_LSB], 2'h0};
    assign critical_scaled = {critical_limit[LIMIT_MSB:LIMIT_LSB], 2'h0};

    always_comb begin
        unique case (state.hysteresis)
            HYST_SEL_NONE: hyst_amount = HYST_NONE;
            HYST_SEL_1P5: hyst_amount = HYST_1P5;
            HYST_SEL_3: hyst_amount = HYST_3;
            HYST_SEL_6: hyst_amount = HYST_6;
        endcase
    end

    assign link.temperature = temperature;
    assign link.hysteresis = hyst_amount;
    assign link.sample_valid = sample_valid;
    assign link.run = !state.shutdown;

    trip_compare #(
        .TRIP_ABOVE(1'b1),
        .INCLUSIVE(1'b1)
    ) critical_cmp (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(link.sink),
        .limit(critical_scaled),
        .tripped(crit_trip)
    );

    trip_compare #(
        .TRIP_ABOVE(1'b1),
        .INCLUSIVE(1'b0)
    ) upper_cmp (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(link.sink),
        .limit(upper_scaled),
        .tripped(upper_trip)
    );

    trip_compare #(
        .TRIP_ABOVE(1'b0),
        .INCLUSIVE(1'b0)
    ) lower_cmp (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(link.sink),
        .limit(lower_scaled),
        .tripped(lower_trip)
    );

    assign locked = state.alarm_lock | state.crit_lock;

    // Limit register writes pass only while their lock is open
    assign upper_write_grant = upper_write_req & !state.alarm_lock;
    assign lower_write_grant = lower_write_req & !state.alarm_lock;
    assign critical_write_grant = critical_write_req & !state.crit_lock;

    // Clear applies only in interrupt mode
    assign clear_request = cfg_write & cfg_wdata[BIT_CLEAR] & state.event_mode;

    always_comb begin
        if (state.shutdown) begin
            event_cond = 1'b0;
        end else if (state.crit_only) begin
            event_cond = crit_trip;
        end else begin
            event_cond = crit_trip | upper_trip | lower_trip;
        end
    end

    assign cond_rise = event_cond & !state.cond_prev;

    // A latched interrupt stays up while critical; critical also holds it alone
    always_comb begin
        if (state.event_mode) begin
            active = state.event_latched | (crit_trip & event_cond);
        end else begin
            active = event_cond;
        end
    end

    assign asserted = active & state.out_enable;

    always_comb begin
        next_state = state;
        next_state.cond_prev = event_cond;

        // Event latch: a new trip wins over a clear in the same cycle
        if (!state.event_mode || !state.out_enable) begin
            next_state.event_latched = 1'b0;
        end else if (cond_rise) begin
            next_state.event_latched = 1'b1;
        end else if (clear_request && !crit_trip) begin
            next_state.event_latched = 1'b0;
        end

        if (cfg_write) begin
            // Status, clear and reserved bits are never stored
            if (!locked) begin
                next_state.event_mode = cfg_wdata[BIT_EVENT_MODE];
                next_state.polarity = cfg_wdata[BIT_POLARITY];
                next_state.crit_only = cfg_wdata[BIT_CRIT_ONLY];
                next_state.out_enable = cfg_wdata[BIT_OUT_ENABLE];
                next_state.shutdown = cfg_wdata[BIT_SHUTDOWN];
            end else begin
                next_state.shutdown = state.shutdown & cfg_wdata[BIT_SHUTDOWN];
            end
            // A single write sets a lock; a zero never releases it
            next_state.alarm_lock = state.alarm_lock | cfg_wdata[BIT_ALARM_LOCK];
            next_state.crit_lock = state.crit_lock | cfg_wdata[BIT_CRIT_LOCK];
            next_state.hysteresis = cfg_wdata[BIT_HYST_HI:BIT_HYST_LO];
        end

        // Status follows the pin, not the write data
        next_state.status = asserted;
        next_state.event_level = asserted ? state.polarity : !state.polarity;
        next_state.event_oe = !next_state.event_level;

        next_state.rdata = CFG_RESET;
        next_state.rdata[BIT_EVENT_MODE] = next_state.event_mode;
        next_state.rdata[BIT_POLARITY] = next_state.polarity;
        next_state.rdata[BIT_CRIT_ONLY] = next_state.crit_only;
        next_state.rdata[BIT_OUT_ENABLE] = next_state.out_enable;
        next_state.rdata[BIT_STATUS] = next_state.status;
        next_state.rdata[BIT_ALARM_LOCK] = next_state.alarm_lock;
        next_state.rdata[BIT_CRIT_LOCK] = next_state.crit_lock;
        next_state.rdata[BIT_SHUTDOWN] = next_state.shutdown;
        next_state.rdata[BIT_HYST_HI:BIT_HYST_LO] = next_state.hysteresis;
    end

    // Only the power-on reset reopens the locks
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= CFG_STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign cfg_rdata = state.rdata;
    assign temperature_sensing = !state.shutdown;
    assign above_critical = crit_trip;
    assign above_alarm = upper_trip;
    assign below_alarm = lower_trip;
    assign event_status = state.status;
    assign event_level = state.event_level;
    // Open-drain pin: pulls low only, the board lifts the high level
    assign event_pin_o = 1'b0;
    assign event_pin_oe = state.event_oe;
endmodule

// ==== testbench/thermal_cfg_sva.sv ====
// Port assertions for the sensor configuration and event block.
// Assumes one clock and sys_rst as the power-on reset.
module thermal_cfg_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_write,
    input wire logic [15:0] cfg_wdata,
    input wire logic [15:0] cfg_rdata,
    input wire logic upper_write_req,
    input wire logic lower_write_req,
    input wire logic critical_write_req,
    input wire logic upper_write_grant,
    input wire logic lower_write_grant,
    input wire logic critical_write_grant,
    input wire logic above_critical,
    input wire logic event_status,
    input wire logic event_level,
    input wire logic event_pin_o,
    input wire logic event_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_crit_on;
        above_critical && cfg_rdata[3] && !cfg_rdata[8] && !cfg_write;
    endsequence
    a_alarm_grant: assert property (
        upper_write_grant == (upper_write_req && !cfg_rdata[6]) &&
        lower_write_grant == (lower_write_req && !cfg_rdata[6]))
        else $error("alarm grant wrong");
    a_crit_grant: assert property (
        critical_write_grant == (critical_write_req && !cfg_rdata[7]))
        else $error("critical grant wrong");
    a_lock_sticky: assert property (|cfg_rdata[7:6] |=>
        (cfg_rdata[7:6] & $past(cfg_rdata[7:6])) == $past(cfg_rdata[7:6]))
        else $error("lock bit dropped");
    a_lock_single: assert property (cfg_write |=>
        (cfg_rdata[7:6] & $past(cfg_wdata[7:6])) == $past(cfg_wdata[7:6]))
        else $error("lock not set by one write");
    a_locked_frozen: assert property ((|cfg_rdata[7:6]) && cfg_write |=>
        cfg_rdata[3:0] == $past(cfg_rdata[3:0]))
        else $error("locked event bits changed");
    a_reserved_zero: assert property (cfg_rdata[15:11] == 5'h00 && !cfg_rdata[5])
        else $error("reserved or clear bit reads one");
    a_shutdown_quiet: assert property (
        cfg_rdata[8] [*2] |-> !event_status && !above_critical)
        else $error("event during shutdown");
    a_disabled_quiet: assert property (!cfg_rdata[3] [*2] |-> !event_status)
        else $error("event while disabled");
    a_level_polarity: assert property ($stable(cfg_rdata[1]) |->
        event_level == (event_status ~^ cfg_rdata[1]))
        else $error("event level wrong");
    a_pin_drive: assert property (event_pin_oe == !event_level && !event_pin_o)
        else $error("pin drive wrong");
    a_crit_holds: assert property (s_crit_on |=> event_status)
        else $error("critical event not held");
endmodule

bind thermal_sensor_config_event_control thermal_cfg_sva thermal_cfg_sva_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg_write(cfg_write),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .upper_write_req(upper_write_req),
    .lower_write_req(lower_write_req),
    .critical_write_req(critical_write_req),
    .upper_write_grant(upper_write_grant),
    .lower_write_grant(lower_write_grant),
    .critical_write_grant(critical_write_grant),
    .above_critical(above_critical),
    .event_status(event_status),
    .event_level(event_level),
    .event_pin_o(event_pin_o),
    .event_pin_oe(event_pin_oe)
);

// ==== testbench/cfg_host.sv ====
// Bus host model: issues one-cycle configuration write strobes.
// Assumes the block samples the strobe on the rising clock edge.
module cfg_host (
    input wire logic clk,
    output logic cfg_write,
    output logic [15:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cfg_write = 1'b0;
        cfg_wdata = 16'h0000;
    end
    // Released data is inverted so a stale word never looks valid
    task automatic put(input logic [15:0] d);
        @(negedge clk);
        cfg_write = 1'b1;
        cfg_wdata = d;
        @(negedge clk);
        cfg_write = 1'b0;
        cfg_wdata = ~d;
    endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench of the sensor configuration block with a register model.
// Assumes the host model and one 25 MHz clock.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import thermal_cfg_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_write;
    logic [15:0] cfg_wdata, cfg_rdata;
    logic [12:0] temperature = 13'h0100;
    logic sample_valid = 1'b0;
    logic [2:0] req = 3'h0;
    logic [2:0] grant;
    logic sensing, above_critical, above_alarm, below_alarm, event_status, event_level;
    logic pin_o, pin_oe;
    logic [15:0] m = 16'h0000;
    logic mst = 1'b0;
    // Model trip flags: bit 0 above alarm, bit 1 below alarm, bit 2 critical
    logic [2:0] tr = 3'h0;
    localparam int UPPER_T = 32'h00000190;
    localparam int LOWER_T = 32'h00000050;
    localparam int CRIT_T = 32'h00000320;
    logic [12:0] hy[4] = '{HYST_NONE, HYST_1P5, HYST_3, HYST_6};
    int errors = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    cfg_host cfg_host_i (.clk(clk), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata));
    thermal_sensor_config_event_control thermal_sensor_config_event_control_i (
        .clk(clk), .sys_rst(sys_rst), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .temperature(temperature), .sample_valid(sample_valid),
        .upper_limit(16'h0190), .lower_limit(16'h0050), .critical_limit(16'h0320),
        .upper_write_req(req[0]), .lower_write_req(req[1]), .critical_write_req(req[2]),
        .upper_write_grant(grant[0]), .lower_write_grant(grant[1]),
        .critical_write_grant(grant[2]), .temperature_sensing(sensing),
        .above_critical(above_critical), .above_alarm(above_alarm),
        .below_alarm(below_alarm), .event_status(event_status), .event_level(event_level),
        .event_pin_o(pin_o), .event_pin_oe(pin_oe));
    task automatic end_of_test();
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic pins();
        `CHK("status", mst, event_status)
        `CHK("level", mst ~^ m[1], event_level)
        `CHK("pin", {~(mst ~^ m[1]), 1'b0}, {pin_oe, pin_o})
        `CHK("trips", tr, {above_critical, below_alarm, above_alarm})
        `CHK("sense", ~m[8], sensing)
        `CHK("cfg", {m[15:5], mst, m[3:0]}, cfg_rdata)
        req = 3'($urandom);
        #1 `CHK("grant", req & ~{m[7], m[6], m[6]}, grant)
    endtask
    task automatic wr(input logic [15:0] d);
        logic lk;
        lk = m[6] | m[7];
        cfg_host_i.put(d);
        if (!lk) m[3:0] = d[3:0];
        if (!lk || !d[8]) m[8] = d[8];
        m[7:6] = m[7:6] | d[7:6];
        m[10:9] = d[10:9];
        if (m[8]) tr = 3'h0;
        @(negedge clk);
        pins();
    endtask
    task automatic samp(input logic [12:0] t, input logic e);
        int hv;
        hv = int'(hy[m[10:9]]);
        @(negedge clk);
        temperature = t;
        sample_valid = 1'b1;
        @(negedge clk);
        sample_valid = 1'b0;
        temperature = 13'($urandom);
        if (m[8]) begin
            tr = 3'h0;
        end else begin
            tr[0] = tr[0] ? (int'(t) > UPPER_T - hv) : (int'(t) > UPPER_T);
            tr[1] = tr[1] ? (int'(t) < LOWER_T + hv) : (int'(t) < LOWER_T);
            tr[2] = tr[2] ? (int'(t) >= CRIT_T - hv) : (int'(t) >= CRIT_T);
        end
        // The interrupt latch adds one edge before the pin follows
        @(negedge clk);
        @(negedge clk);
        mst = e;
        pins();
    endtask
    initial begin
        void'($urandom(9));
        repeat (16) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        pins();
        wr(16'h0008);
        samp(13'h0200, 1'b1);
        samp(13'h0100, 1'b0);
        samp(13'h0010, 1'b1);
        samp(13'h0200, 1'b1);
        wr(16'h0028);
        wr(16'h000A);
        samp(13'h0100, 1'b0);
        wr(16'h0009);
        samp(13'h0200, 1'b1);
        samp(13'h0100, 1'b1);
        wr(16'h0019);
        mst = 1'b0;
        wr(16'h0029);
        samp(13'h0400, 1'b1);
        wr(16'h0029);
        samp(13'h0100, 1'b1);
        mst = 1'b0;
        wr(16'h0029);
        wr(16'h000C);
        samp(13'h0200, 1'b0);
        samp(13'h0400, 1'b1);
        samp(13'h0100, 1'b0);
        wr(16'h0000);
        samp(13'h0400, 1'b0);
        wr(16'h0108);
        samp(13'h0400, 1'b0);
        `CHK("crit", 1'b0, above_critical)
        for (int i = 0; i < 4; i++) begin
            wr({5'h00, 2'(i), 9'h008});
            samp(13'h0200, 1'b1);
            samp(13'h0191 - hy[i], 1'b1);
            samp(13'h0190 - hy[i], 1'b0);
        end
        for (int i = 0; i < 12; i++) wr(16'($urandom) & 16'hFF3F);
        wr(16'h0140);
        wr(16'h0000);
        wr(16'h0100);
        wr(16'h0080);
        for (int i = 0; i < 12; i++) wr(16'($urandom));
        @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        m = 16'h0000;
        tr = 3'h0;
        pins();
        end_of_test();
    end
    // About 250 cycles are needed; allow about ten times that before giving up
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
endmodule
